// [rtl/ftz_pkg.sv]
/*
 * ftz_pkg: widths, option bit positions, status codes, kind codes,
 * reset values, timing counts and state types of the flow totalizer front end.
 * assumes a 250 MHz clock; values are signed fixed point with FRAC fraction bits.
 */
package ftz_pkg;
    localparam int VAL_W = 32;
    localparam int FRAC  = 16;
    localparam int TOT_W = 48;
    localparam int OPT_W = 16;
    localparam int HOLD_W = 31;

    // option word bit positions
    localparam int OPT_ACC1 = 0;
    localparam int OPT_ACC2 = 1;
    localparam int OPT_FWD  = 2;
    localparam int OPT_REV  = 3;
    localparam int OPT_UNC  = 4;
    localparam int OPT_BAD  = 5;
    localparam int OPT_ZERO = 7;

    // input status codes; the unused code is handled as bad
    localparam logic [1:0] ST_BAD  = 2'h0;
    localparam logic [1:0] ST_UNC  = 2'h1;
    localparam logic [1:0] ST_GOOD = 2'h2;

    // accumulation kinds
    localparam logic [2:0] KIND_UP_SELF   = 3'h1;
    localparam logic [2:0] KIND_UP_REQ    = 3'h2;
    localparam logic [2:0] KIND_DOWN_SELF = 3'h3;
    localparam logic [2:0] KIND_DOWN_REQ  = 3'h4;
    localparam logic [2:0] KIND_INTERVAL  = 3'h5;
    localparam logic [2:0] KIND_REQUEST   = 3'h6;
    localparam logic [2:0] KIND_INT_REQ   = 3'h7;

    // reset values
    localparam logic signed [VAL_W-1:0] VAL_RST = 32'h0000_0000;
    localparam logic signed [TOT_W-1:0] TOT_RST = 48'h0000_0000_0000;
    localparam logic [HOLD_W-1:0]       HOLD_RST = 31'h0000_0000;
    localparam logic [31:0]             PCNT_RST = 32'h0000_0000;

    // reset hold-off time and its cycle count, rounded up
    localparam longint unsigned HOLDOFF_S     = 5;
    localparam longint unsigned NS_PER_S      = 1_000_000_000;
    localparam longint unsigned CLK_PERIOD_NS = 4;
    localparam longint unsigned HOLDOFF_CYCLES_DFLT =
        (HOLDOFF_S * NS_PER_S + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    typedef struct packed {
        logic signed [VAL_W-1:0] prev;
        logic signed [VAL_W-1:0] last_good;
        logic                    has_prev;
    } ftz_chan_state_t;

    typedef struct packed {
        logic signed [TOT_W-1:0] total;
        logic signed [TOT_W-1:0] abs_sum;
        logic signed [TOT_W-1:0] bad_sum;
        logic signed [TOT_W-1:0] life;
        logic signed [TOT_W-1:0] out_value;
        logic [HOLD_W-1:0]       holdoff;
        logic [31:0]             pcount;
        logic                    trip;
        logic                    ptrip;
        logic                    reset_event;
        logic                    op_clear;
        logic                    kind_error;
    } ftz_state_t;

    // signed fixed point product, cut back to value width
    function automatic logic signed [VAL_W-1:0] ftz_mulq(
        input logic signed [VAL_W-1:0] a,
        input logic signed [VAL_W-1:0] b);
        logic signed [2*VAL_W-1:0] p;
        p = a * b;
        return p[FRAC +: VAL_W];
    endfunction : ftz_mulq
endpackage : ftz_pkg

// [rtl/ftz_chan_if.sv]
/*
 * ftz_chan_if: carries one input channel's value, status and settings
 * to the channel stage and its increment back.
 * assumes both ends run on the same clock.
 */
`timescale 1ns/1ns
`default_nettype none
interface ftz_chan_if;
    import ftz_pkg::*;
    logic                    tick;
    logic signed [VAL_W-1:0] value;
    logic [1:0]              status;
    logic                    accum_mode;
    logic                    reverse;
    logic                    use_unc;
    logic                    use_bad;
    logic                    apply_ratio;
    logic signed [VAL_W-1:0] time_factor;
    logic signed [VAL_W-1:0] weight;
    logic signed [VAL_W-1:0] ratio;
    logic signed [VAL_W-1:0] period;
    logic signed [VAL_W-1:0] incr;
    logic                    good;
    modport ctl  (output tick, value, status, accum_mode, reverse, use_unc, use_bad,
                  apply_ratio, time_factor, weight, ratio, period,
                  input incr, good);
    modport chan (input tick, value, status, accum_mode, reverse, use_unc, use_bad,
                  apply_ratio, time_factor, weight, ratio, period,
                  output incr, good);
endinterface : ftz_chan_if
`default_nettype wire

// [rtl/ftz_chan.sv]
/*
 * ftz_chan: one input channel: status qualification, last good value,
 * rate or counter conversion and flow direction.
 * assumes settings are stable around the execution tick.
 */
`timescale 1ns/1ns
`default_nettype none
module ftz_chan (
    input wire logic clk,
    input wire logic rst,
    ftz_chan_if.chan ch
);
    import ftz_pkg::*;

    ftz_chan_state_t         s;
    ftz_chan_state_t         next_s;
    logic                    raw_bad;
    logic signed [VAL_W-1:0] used;
    logic signed [VAL_W-1:0] conv;

    always_comb begin
        raw_bad = (ch.status != ST_GOOD) && (ch.status != ST_UNC);
        // qualify, then convert, then apply direction
        ch.good = (ch.status == ST_GOOD) || ((ch.status == ST_UNC) && ch.use_unc)
                  || (raw_bad && ch.use_bad);
        used = raw_bad ? s.last_good : ch.value;
        if (ch.accum_mode) begin
            // first sample after reset has no predecessor, so it adds nothing
            conv = ftz_mulq(s.has_prev ? used - s.prev : VAL_RST, ch.weight);
            if (ch.apply_ratio) begin
                conv = ftz_mulq(conv, ch.ratio);
            end
        end else begin
            conv = ftz_mulq(used, ch.time_factor);
            if (ch.apply_ratio) begin
                conv = ftz_mulq(conv, ch.ratio);
            end
            conv = ftz_mulq(conv, ch.period);
        end
        ch.incr = ch.reverse ? -conv : conv;
        next_s = s;
        if (ch.tick) begin
            next_s.prev = used;
            next_s.has_prev = 1'b1;
            // only a raw good sample refreshes the substitute; uncertain never does
            if (ch.status == ST_GOOD) begin
                next_s.last_good = ch.value;
            end
        end
    end

    // values are volatile; the direction flag lives in the parameter store
    always_ff @(posedge clk) begin
        if (rst) begin
            s <= '{prev: VAL_RST, last_good: VAL_RST, has_prev: 1'b0};
        end else begin
            s <= next_s;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    good_kept_a: assert property ((ch.status == ST_GOOD) |-> ch.good)
        else $error("good input status not kept good");
    bad_demoted_a: assert property ((ch.status == ST_BAD && !ch.use_bad) |-> !ch.good)
        else $error("bad input promoted without option");
    last_good_a: assert property ((ch.tick && ch.status == ST_BAD)
        |=> s.last_good == $past(s.last_good) && s.prev == $past(s.last_good))
        else $error("last good value replaced by bad sample");
    sign_flip_a: assert property ((ch.reverse && !ch.accum_mode && !ch.apply_ratio)
        |-> ch.incr == -ftz_mulq(ftz_mulq(used, ch.time_factor), ch.period))
        else $error("reverse flow did not negate increment");
endmodule : ftz_chan
`default_nettype wire

// [rtl/ftz_front.sv]
/*
 * ftz_front: two-input flow totalizer front end: input channels, adder and
 * the four running totals, three of them cleared by kind-dependent reset triggers or the operator reset command (lifetime never), and trip flags.
 * assumes all inputs come from logic on clk and exec_tick is a one-cycle pulse.
 */
`timescale 1ns/1ns
`default_nettype none
module ftz_front #(
    parameter int unsigned HOLDOFF_CYCLES = 32'(ftz_pkg::HOLDOFF_CYCLES_DFLT)
) (
    input  wire logic                          clk,
    input  wire logic                          rst,
    input  wire logic                          exec_tick,
    input  wire logic signed [ftz_pkg::VAL_W-1:0]   primary_value,
    input  wire logic [1:0]                    primary_status,
    input  wire logic                          primary_connected,
    input  wire logic signed [ftz_pkg::VAL_W-1:0]   secondary_value,
    input  wire logic [1:0]                    secondary_status,
    input  wire logic                          secondary_connected,
    input  wire logic [ftz_pkg::OPT_W-1:0]     totalizer_option_word,
    input  wire logic                          primary_reverse_flag,
    input  wire logic                          secondary_reverse_flag,
    input  wire logic [2*ftz_pkg::VAL_W-1:0]   time_base_factors,
    input  wire logic signed [ftz_pkg::VAL_W-1:0]   secondary_unit_ratio,
    input  wire logic signed [ftz_pkg::VAL_W-1:0]   primary_pulse_weight,
    input  wire logic signed [ftz_pkg::VAL_W-1:0]   secondary_pulse_weight,
    input  wire logic signed [ftz_pkg::VAL_W-1:0]   exec_period,
    input  wire logic [2:0]                    accumulation_kind,
    input  wire logic signed [ftz_pkg::VAL_W-1:0]   total_setpoint,
    input  wire logic signed [ftz_pkg::VAL_W-1:0]   pre_trip_margin,
    input  wire logic [31:0]                   interval_cleared_reset_interval,
    input  wire logic                          reset_request,
    input  wire logic                          operator_reset_command,
    output logic signed [ftz_pkg::TOT_W-1:0]   out_value,
    output logic signed [ftz_pkg::TOT_W-1:0]   absolute_sum,
    output logic signed [ftz_pkg::TOT_W-1:0]   bad_status_sum_output,
    output logic signed [ftz_pkg::TOT_W-1:0]   lifetime_sum,
    output logic                               trip_flag,
    output logic                               pre_trip_flag,
    output logic                               reset_event,
    output logic                               operator_command_clear,
    output logic                               kind_error
);
    import ftz_pkg::*;

    ftz_chan_if pri_if ();
    ftz_chan_if sec_if ();

    ftz_state_t              s;
    ftz_state_t              next_s;
    logic                    fwd_only;
    logic                    rev_only;
    logic signed [VAL_W-1:0] pv;
    logic signed [VAL_W-1:0] sv;
    logic                    sum_bad;
    logic signed [TOT_W-1:0] inc;
    logic signed [TOT_W-1:0] mag;
    logic signed [TOT_W-1:0] sp_ext;
    logic signed [TOT_W-1:0] pre_ext;
    logic signed [TOT_W-1:0] out_int;
    logic                    kind_ok;
    logic                    down;
    logic                    trip_kind;
    logic                    trig_auto;
    logic                    trig_req;
    logic                    trig_int;
    logic                    do_reset;

    // channel wiring; the ratio is applied to the secondary only
    assign pri_if.tick        = exec_tick;
    assign pri_if.value       = primary_value;
    assign pri_if.status      = primary_status;
    assign pri_if.accum_mode  = totalizer_option_word[OPT_ACC1];
    assign pri_if.reverse     = primary_reverse_flag;
    assign pri_if.use_unc     = totalizer_option_word[OPT_UNC];
    assign pri_if.use_bad     = totalizer_option_word[OPT_BAD];
    assign pri_if.apply_ratio = 1'b0;
    assign pri_if.time_factor = time_base_factors[VAL_W-1:0];
    assign pri_if.weight      = primary_pulse_weight;
    assign pri_if.ratio       = secondary_unit_ratio;
    assign pri_if.period      = exec_period;

    assign sec_if.tick        = exec_tick;
    assign sec_if.value       = secondary_value;
    assign sec_if.status      = secondary_status;
    assign sec_if.accum_mode  = totalizer_option_word[OPT_ACC2];
    assign sec_if.reverse     = secondary_reverse_flag;
    assign sec_if.use_unc     = totalizer_option_word[OPT_UNC];
    assign sec_if.use_bad     = totalizer_option_word[OPT_BAD];
    assign sec_if.apply_ratio = 1'b1;
    assign sec_if.time_factor = time_base_factors[2*VAL_W-1:VAL_W];
    assign sec_if.weight      = secondary_pulse_weight;
    assign sec_if.ratio       = secondary_unit_ratio;
    assign sec_if.period      = exec_period;

    ftz_chan u_pri (
        .clk (clk),
        .rst (rst),
        .ch  (pri_if.chan)
    );

    ftz_chan u_sec (
        .clk (clk),
        .rst (rst),
        .ch  (sec_if.chan)
    );

    always_comb begin
        next_s = s;
        next_s.reset_event = 1'b0;
        next_s.op_clear = 1'b0;
        kind_ok = (accumulation_kind >= KIND_UP_SELF) && (accumulation_kind <= KIND_INT_REQ);
        next_s.kind_error = !kind_ok;
        down = (accumulation_kind == KIND_DOWN_SELF) || (accumulation_kind == KIND_DOWN_REQ);
        trip_kind = kind_ok && (accumulation_kind <= KIND_DOWN_REQ);
        sp_ext = TOT_W'(total_setpoint);
        pre_ext = TOT_W'(pre_trip_margin);
        if (s.holdoff != HOLD_RST) begin
            next_s.holdoff = s.holdoff - HOLD_W'(1);
        end

        // adder: equal option bits add as is
        fwd_only = totalizer_option_word[OPT_FWD] && !totalizer_option_word[OPT_REV];
        rev_only = totalizer_option_word[OPT_REV] && !totalizer_option_word[OPT_FWD];
        pv = primary_connected ? pri_if.incr : VAL_RST;
        sv = secondary_connected ? sec_if.incr : VAL_RST;
        if ((fwd_only && pv < 0) || (rev_only && pv > 0)) begin
            pv = VAL_RST;
        end
        if ((fwd_only && sv < 0) || (rev_only && sv > 0)) begin
            sv = VAL_RST;
        end
        sum_bad = (primary_connected && !pri_if.good)
                  || (secondary_connected && !sec_if.good);
        inc = TOT_W'(pv) + TOT_W'(sv);
        if (totalizer_option_word[OPT_ZERO] && sum_bad) begin
            inc = TOT_RST;
        end
        mag = (inc < 0) ? -inc : inc;

        trig_auto = 1'b0;
        trig_req = 1'b0;
        trig_int = 1'b0;
        out_int = down ? sp_ext - s.total : s.total;
        if (exec_tick && kind_ok) begin
            // one evaluation per tick; MAN-style hold is left to the caller
            next_s.total = s.total + inc;
            next_s.abs_sum = s.abs_sum + mag;
            if (sum_bad) begin
                next_s.bad_sum = s.bad_sum + mag;
            end
            next_s.life = s.life + inc;
            next_s.pcount = s.pcount + 32'h0000_0001;
            out_int = down ? sp_ext - next_s.total : next_s.total;
            trig_auto = (accumulation_kind == KIND_UP_SELF && out_int >= sp_ext)
                        || (accumulation_kind == KIND_DOWN_SELF && out_int <= TOT_RST);
            trig_req = reset_request && (accumulation_kind != KIND_INTERVAL);
            trig_int = ((accumulation_kind == KIND_INTERVAL) || (accumulation_kind == KIND_INT_REQ))
                       && (interval_cleared_reset_interval != PCNT_RST)
                       && (next_s.pcount >= interval_cleared_reset_interval);
        end
        // a lower bound of one tick is natural: triggers are only seen on ticks
        do_reset = exec_tick && (s.holdoff == HOLD_RST)
                   && (trig_auto || trig_req || trig_int || operator_reset_command);
        if (do_reset) begin
            next_s.total = TOT_RST;
            next_s.abs_sum = TOT_RST;
            next_s.bad_sum = TOT_RST;
            next_s.pcount = PCNT_RST;
            next_s.holdoff = HOLD_W'(HOLDOFF_CYCLES);
            next_s.reset_event = 1'b1;
            next_s.op_clear = operator_reset_command;
            out_int = down ? sp_ext : TOT_RST;
        end
        next_s.out_value = out_int;
        next_s.trip = trip_kind && (down ? out_int <= TOT_RST : out_int >= sp_ext);
        next_s.ptrip = trip_kind && (down ? out_int <= pre_ext : out_int >= sp_ext - pre_ext);
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            s <= '{total: TOT_RST, abs_sum: TOT_RST, bad_sum: TOT_RST, life: TOT_RST,
                   out_value: TOT_RST, holdoff: HOLD_RST, pcount: PCNT_RST,
                   trip: 1'b0, ptrip: 1'b0, reset_event: 1'b0, op_clear: 1'b0,
                   kind_error: 1'b0};
        end else begin
            s <= next_s;
        end
    end

    assign out_value              = s.out_value;
    assign absolute_sum           = s.abs_sum;
    assign bad_status_sum_output  = s.bad_sum;
    assign lifetime_sum           = s.life;
    assign trip_flag              = s.trip;
    assign pre_trip_flag          = s.ptrip;
    assign reset_event            = s.reset_event;
    assign operator_command_clear = s.op_clear;
    assign kind_error             = s.kind_error;

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    sequence reset_taken;
        reset_event ##1 (s.holdoff == HOLD_W'(HOLDOFF_CYCLES - 1));
    endsequence

    holdoff_load_a: assert property (reset_event |-> s.holdoff == HOLD_W'(HOLDOFF_CYCLES))
        else $error("hold-off not loaded on reset");
    holdoff_block_a: assert property ((s.holdoff > HOLD_W'(1)) |=> !reset_event)
        else $error("reset accepted during hold-off");
    holdoff_count_a: assert property ((reset_event && HOLDOFF_CYCLES > 1) |-> reset_taken)
        else $error("hold-off not counting down");
    totals_clear_a: assert property (reset_event |-> s.total == 0 && absolute_sum == 0
        && bad_status_sum_output == 0)
        else $error("totals not cleared on reset");
    life_kept_a: assert property ((exec_tick && kind_ok && do_reset)
        |=> lifetime_sum == $past(s.life) + $past(inc))
        else $error("lifetime total disturbed by reset");
    tick_only_a: assert property (!$past(exec_tick) |-> $stable(lifetime_sum)
        && $stable(absolute_sum))
        else $error("totals moved without a tick");
    zero_bad_a: assert property ((exec_tick && totalizer_option_word[OPT_ZERO] && sum_bad)
        |=> $stable(lifetime_sum))
        else $error("bad increment not zeroed");
    kind_range_a: assert property ((exec_tick && !kind_ok) |=> $stable(lifetime_sum) && kind_error)
        else $error("illegal kind integrated");
    no_trip_a: assert property ((accumulation_kind >= KIND_INTERVAL) |=> !trip_flag && !pre_trip_flag)
        else $error("trip flag for a kind without trips");
endmodule : ftz_front
`default_nettype wire

// [tb/ftz_upstream.sv]
/*
 * ftz_upstream: upstream block that feeds one input of the totalizer front end.
 * assumes the bench changes the wanted value and status off the rising edge.
 */
`timescale 1ns/1ns
`default_nettype none
module ftz_upstream (
    input  wire logic                             clk,
    input  wire logic                             linked,
    input  wire logic signed [ftz_pkg::VAL_W-1:0] want,
    input  wire logic [1:0]                       want_status,
    output logic signed [ftz_pkg::VAL_W-1:0]      value,
    output logic [1:0]                            status
);
    import ftz_pkg::*;
    // an unlinked source shows noise, so a stale copy can never pass for data
    logic [VAL_W-1:0] noise = 32'hA5C3_3C5A;
    always @(posedge clk) begin
        noise <= {noise[VAL_W-2:0], noise[VAL_W-1] ^ noise[21]};
    end
    assign value  = linked ? want : noise;
    assign status = linked ? want_status : noise[1:0];
endmodule : ftz_upstream
`default_nettype wire

// [tb/tb.sv]
/*
 * tb: random and corner ticks through the flow totalizer front end, totals
 * checked against a reference kept here.
 * assumes ftz_pkg, the design files and ftz_upstream are compiled first.
 */
`timescale 1ns/1ns
`default_nettype none
module tb;
    import ftz_pkg::*;
    logic                    clk = 1'b0;
    logic                    rst = 1'b1;
    logic                    tick = 1'b0;
    logic                    req = 1'b0;
    logic                    opc = 1'b0;
    logic                    lk[2] = '{1'b1, 1'b1};
    logic                    rv[2] = '{1'b0, 1'b0};
    logic [1:0]              st[2] = '{ST_GOOD, ST_GOOD};
    logic [OPT_W-1:0]        opt = 16'h0000;
    logic [2:0]              kind = 3'h2;
    int                      v[2] = '{0, 0};
    int                      tf[2] = '{32'h10000, 32'h10000};
    int                      w[2] = '{32'h10000, 32'h10000};
    int                      lg[2] = '{0, 0};
    int                      pv[2] = '{0, 0};
    int                      ratio = 32'h10000;
    int                      per = 32'h10000;
    int                      sp = 0;
    int                      pm = 0, pint = 0;
    bit                      hp = 1'b0;
    longint                  tot = 0, ab = 0, bd = 0, lf = 0;
    int                      bad_count = 0, cmp_count = 0;
    logic signed [VAL_W-1:0] pval, sval;
    logic [1:0]              pst, sst;
    logic signed [TOT_W-1:0] outv, abss, bads, life;
    logic                    trip, ptrip, rev_ev, occ, kerr;

    ftz_upstream ftz_upstream_i (.clk(clk), .linked(lk[0]), .want(v[0]), .want_status(st[0]),
        .value(pval), .status(pst));
    ftz_upstream ftz_upstream_s_i (.clk(clk), .linked(lk[1]), .want(v[1]), .want_status(st[1]),
        .value(sval), .status(sst));
    // short hold-off so the reset lockout is seen within a few ticks
    ftz_front #(.HOLDOFF_CYCLES(20)) ftz_front_i (.clk(clk), .rst(rst), .exec_tick(tick),
        .primary_value(pval), .primary_status(pst), .primary_connected(lk[0]),
        .secondary_value(sval), .secondary_status(sst), .secondary_connected(lk[1]),
        .totalizer_option_word(opt), .primary_reverse_flag(rv[0]), .secondary_reverse_flag(rv[1]),
        .time_base_factors({tf[1], tf[0]}), .secondary_unit_ratio(ratio), .primary_pulse_weight(w[0]),
        .secondary_pulse_weight(w[1]), .exec_period(per), .accumulation_kind(kind), .total_setpoint(sp),
        .pre_trip_margin(pm), .interval_cleared_reset_interval(pint), .reset_request(req),
        .operator_reset_command(opc), .out_value(outv), .absolute_sum(abss),
        .bad_status_sum_output(bads), .lifetime_sum(life), .trip_flag(trip), .pre_trip_flag(ptrip),
        .reset_event(rev_ev), .operator_command_clear(occ), .kind_error(kerr));

    initial begin
        forever #2 clk = ~clk;
    end

    function automatic longint mq(longint a, longint b);
        return (a * b) >>> 16;
    endfunction : mq

    function automatic bit qb(int c);
        return lk[c] && !(st[c] == ST_GOOD || (st[c] == ST_UNC && opt[OPT_UNC]) || (st[c] == ST_BAD && opt[OPT_BAD]));
    endfunction : qb

    function automatic longint chan(int c);
        longint x;
        int     u;
        u = (st[c] == ST_BAD) ? lg[c] : v[c];
        x = opt[OPT_ACC1+c] ? (hp ? mq(u - pv[c], w[c]) : 0) : mq(u, tf[c]);
        if (c == 1) x = mq(x, ratio);
        if (!opt[OPT_ACC1+c]) x = mq(x, per);
        if (rv[c]) x = -x;
        if (opt[OPT_FWD] && !opt[OPT_REV] && x < 0) x = 0;
        if (opt[OPT_REV] && !opt[OPT_FWD] && x > 0) x = 0;
        return lk[c] ? x : 0;
    endfunction : chan

    task automatic chk(input logic [63:0] g, input longint e);
        cmp_count++;
        if (g !== e) begin
            bad_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask : chk

    task automatic step(input bit rs);
        longint i;
        longint o;
        bit     b;
        bit     dn;
        i = chan(0) + chan(1);
        b = qb(0) || qb(1);
        // an illegal kind integrates nothing at all
        if ((b && opt[OPT_ZERO]) || kind == 3'h0) i = 0;
        dn = (kind == KIND_DOWN_SELF) || (kind == KIND_DOWN_REQ);
        // self-clearing kinds reset when the output reaches its threshold
        if ((kind == KIND_UP_SELF && tot + i >= sp) || (kind == KIND_DOWN_SELF && sp - tot - i <= 0)) rs = 1'b1;
        lf += i;
        tot = rs ? 0 : tot + i;
        ab = rs ? 0 : ab + (i < 0 ? -i : i);
        bd = rs ? 0 : bd + (b ? (i < 0 ? -i : i) : 0);
        for (int c = 0; c < 2; c++) begin
            pv[c] = (st[c] == ST_BAD) ? lg[c] : v[c];
            if (st[c] == ST_GOOD) lg[c] = v[c];
        end
        hp = 1'b1;
        o = dn ? longint'(sp) - tot : tot;
        @(negedge clk) tick = 1'b1;
        @(negedge clk) tick = 1'b0;
        chk(64'(outv), o);
        chk(64'({trip, ptrip}), (kind < KIND_UP_SELF || kind > KIND_DOWN_REQ) ? 0
            : dn ? 2 * (o <= 0) + (o <= pm) : 2 * (o >= sp) + (o >= longint'(sp) - pm));
        chk(64'(abss), ab);
        chk(64'(bads), bd);
        chk(64'(life), lf);
        chk(64'({rev_ev, occ}), 2 * rs + (rs & opc));
    endtask : step

    task automatic complete_run();
        $display("compares %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : complete_run

    initial begin
        repeat (5000) @(posedge clk);
        bad_count++;
        complete_run();
    end

    initial begin
        void'($urandom(38));
        repeat (16) @(negedge clk);
        rst = 1'b0;
        sp = $urandom_range(32'h0010_0000, 32'h7FFF_0000);
        // both inputs stay linked here: an unlinked source's noise would spoil the counter history
        for (int n = 0; n < 200; n++) begin
            for (int c = 0; c < 2; c++) begin
                v[c] = $urandom_range(0, 32'h0020_0000) - 32'h0010_0000;
                st[c] = ($urandom_range(0, 2) == 0) ? ST_BAD : ST_GOOD;
                rv[c] = 1'($urandom_range(0, 1));
                tf[c] = $urandom_range(32'h8000, 32'h18000);
                w[c] = $urandom_range(32'h8000, 32'h18000);
            end
            ratio = $urandom_range(32'h8000, 32'h18000);
            per = $urandom_range(32'h8000, 32'h18000);
            pm = $urandom_range(0, sp);
            opt = 16'($urandom) & 16'h00BF;
            kind = 3'(2 * $urandom_range(1, 3));
            step(1'b0);
        end
        $display("test random done");
        st = '{ST_UNC, ST_UNC};
        opt = 16'h0080;
        repeat (2) begin
            step(1'b0);
            opt[OPT_UNC] = 1'b1;
        end
        st = '{ST_GOOD, ST_GOOD};
        opt = 16'h0000;
        for (int c = 0; c < 2; c++) begin
            lk[c] = 1'b0;
            step(1'b0);
            lk[c] = 1'b1;
        end
        $display("test corners done");
        sp = 0;
        pm = 0;
        kind = KIND_UP_REQ;
        req = 1'b1;
        step(1'b1);
        step(1'b0);
        req = 1'b0;
        repeat (24) @(negedge clk);
        opc = 1'b1;
        step(1'b1);
        opc = 1'b0;
        $display("test reset done");
        for (int k = 0; k < 8; k++) begin
            kind = 3'(k);
            @(negedge clk);
            chk(64'({trip, ptrip, kerr}), (k >= 1 && k <= 4) ? 6 : (k == 0));
        end
        kind = 3'h0;
        step(1'b0);
        $display("test kinds done");
        // unit inputs give 2.0 per tick, so a threshold of 5.0 is crossed on the third tick
        v = '{32'h10000, 32'h10000};
        tf = v;
        rv = '{1'b0, 1'b0};
        ratio = 32'h10000;
        per = 32'h10000;
        sp = 32'h50000;
        pint = 3;
        for (int k = 1; k <= 7; k += 2) begin
            kind = 3'(k);
            // let the hold-off of the previous reset run out first
            repeat (24) @(negedge clk);
            for (int n = 0; n < 3; n++) begin
                step(k > 4 && n == 2);
            end
        end
        $display("test auto and interval done");
        complete_run();
    end
endmodule : tb
`default_nettype wire
